// file: hw/apu_pulser.sv
/*
 alarm output pulser: settings edited over axi4-lite, applied on confirm,
 drives one alarm pin continuous or pulsed with chosen polarity.
 assumes: ALARM_I is asynchronous; 100 MHz clock; one write and one read
 in flight at a time from the master.
*/
// Register access over AXI4-Lite and the placing of the registers were left to the implementer.
// Overview of operation
// [R01] - high-active: output low when idle, high during alarm
// [R02] - low-active: output high when idle, low during alarm
// [R03] - reset or default restore selects high-active polarity
// [R04] - continuous mode holds output active for the whole alarm
// [R05] - pulsed mode alternates active and inactive while alarm persists
// [R06] - reset or default restore selects pulsed mode
// [R07] - off phase lasts programmable seconds, default five
// [R08] - on phase lasts programmable seconds, default five
// [R09] - whole edited set applied only on confirm; cancel keeps active set
// [R10] - alarm starts with on phase; alarm end returns inactive, clears timer
`timescale 1ns/1ps
`default_nettype none
`include "apu_consts.svh"

module apu_pulser #(
    parameter int unsigned CYC_PER_SEC = `APU_CYC_PER_SEC
) (
    input wire logic CLK_I,
    input wire logic RESETN_I,
    input wire logic ALARM_I,
    output logic ALARM_O,
    input wire logic [`APU_ADDR_W-1:0] S_AXI_AWADDR_I,
    input wire logic S_AXI_AWVALID_I,
    output logic S_AXI_AWREADY_O,
    input wire logic [31:0] S_AXI_WDATA_I,
    input wire logic [3:0] S_AXI_WSTRB_I,
    input wire logic S_AXI_WVALID_I,
    output logic S_AXI_WREADY_O,
    output logic [1:0] S_AXI_BRESP_O,
    output logic S_AXI_BVALID_O,
    input wire logic S_AXI_BREADY_I,
    input wire logic [`APU_ADDR_W-1:0] S_AXI_ARADDR_I,
    input wire logic S_AXI_ARVALID_I,
    output logic S_AXI_ARREADY_O,
    output logic [31:0] S_AXI_RDATA_O,
    output logic [1:0] S_AXI_RRESP_O,
    output logic S_AXI_RVALID_O,
    input wire logic S_AXI_RREADY_I
);

    localparam apu_pkg::apu_cfg_t CFG_DEFAULT = '{
        low_act: `APU_DEF_LOW_ACT,
        cont: `APU_DEF_CONT,
        toff: `APU_DEF_TOFF,
        ton: `APU_DEF_TON
    };

    // alarm pin synchroniser
    logic sync1_reg;
    logic sync2_reg;

    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
        end else begin
            sync1_reg <= ALARM_I;
            sync2_reg <= sync1_reg;
        end
    end

    // settings: edit copy and active copy
    apu_pkg::apu_cfg_t edit_reg;
    apu_pkg::apu_cfg_t edit_next;
    apu_pkg::apu_cfg_t act_reg;
    apu_pkg::apu_cfg_t act_next;

    // axi write side
    logic aw_hold_reg;
    logic aw_hold_next;
    logic [`APU_ADDR_W-1:0] aw_addr_reg;
    logic [`APU_ADDR_W-1:0] aw_addr_next;
    logic w_hold_reg;
    logic w_hold_next;
    logic [31:0] w_data_reg;
    logic [31:0] w_data_next;
    logic [3:0] w_strb_reg;
    logic [3:0] w_strb_next;
    logic awready_reg;
    logic awready_next;
    logic wready_reg;
    logic wready_next;
    logic bvalid_reg;
    logic bvalid_next;
    logic [1:0] bresp_reg;
    logic [1:0] bresp_next;
    logic do_write;

    // axi read side
    logic arready_reg;
    logic arready_next;
    logic rvalid_reg;
    logic rvalid_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic [1:0] rresp_reg;
    logic [1:0] rresp_next;

    // phase machine
    apu_pkg::apu_phase_t phase_reg;
    apu_pkg::apu_phase_t phase_next;
    logic [`APU_TIME_W-1:0] sec_reg;
    logic [`APU_TIME_W-1:0] sec_next;
    logic out_reg;
    logic out_next;
    logic tick;
    logic restart;

    // byte-lane merge for the narrow time fields
    function automatic logic [`APU_TIME_W-1:0] merge16(
        input logic [`APU_TIME_W-1:0] old_v,
        input logic [31:0] data,
        input logic [3:0] strb
    );
        logic [`APU_TIME_W-1:0] v;
        v = old_v;
        if (strb[0]) v[7:0] = data[7:0];
        if (strb[1]) v[15:8] = data[15:8];
        return v;
    endfunction

    // zero seconds would stall a phase, so it counts as one
    function automatic logic [`APU_TIME_W-1:0] eff_time(input logic [`APU_TIME_W-1:0] t);
        return (t == '0) ? `APU_TIME_MIN : t;
    endfunction

    function automatic logic [31:0] ctrl_word(input apu_pkg::apu_cfg_t c);
        logic [31:0] w;
        w = 32'h00000000;
        w[`APU_CTRL_LOW_BIT] = c.low_act;
        w[`APU_CTRL_CONT_BIT] = c.cont;
        return w;
    endfunction

    assign do_write = aw_hold_reg && w_hold_reg && !bvalid_reg;

    always_comb begin
        aw_hold_next = aw_hold_reg;
        aw_addr_next = aw_addr_reg;
        w_hold_next = w_hold_reg;
        w_data_next = w_data_reg;
        w_strb_next = w_strb_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        edit_next = edit_reg;
        act_next = act_reg;
        if (S_AXI_AWVALID_I && awready_reg) begin
            aw_hold_next = 1'b1;
            aw_addr_next = S_AXI_AWADDR_I;
        end
        if (S_AXI_WVALID_I && wready_reg) begin
            w_hold_next = 1'b1;
            w_data_next = S_AXI_WDATA_I;
            w_strb_next = S_AXI_WSTRB_I;
        end
        if (bvalid_reg && S_AXI_BREADY_I) begin
            bvalid_next = 1'b0;
        end
        if (do_write) begin
            aw_hold_next = 1'b0;
            w_hold_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = `APU_RESP_OKAY;
            unique case (aw_addr_reg)
                `APU_OFF_EDIT_CTRL: begin
                    if (w_strb_reg[0]) begin
                        edit_next.low_act = w_data_reg[`APU_CTRL_LOW_BIT];
                        edit_next.cont = w_data_reg[`APU_CTRL_CONT_BIT];
                    end
                end
                `APU_OFF_EDIT_TOFF: begin
                    edit_next.toff = merge16(edit_reg.toff, w_data_reg, w_strb_reg);
                end
                `APU_OFF_EDIT_TON: begin
                    edit_next.ton = merge16(edit_reg.ton, w_data_reg, w_strb_reg);
                end
                `APU_OFF_COMMAND: begin
                    if (w_strb_reg[0]) begin
                        if (w_data_reg[`APU_CMD_DEFAULT_BIT]) begin
                            edit_next = CFG_DEFAULT; // [R03] [R06] [R07] [R08]
                        end
                        if (w_data_reg[`APU_CMD_APPLY_BIT]) begin
                            act_next = edit_next; // [R09]
                        end else if (w_data_reg[`APU_CMD_CANCEL_BIT]) begin
                            edit_next = act_reg; // [R09]
                        end
                    end
                end
                `APU_OFF_ACT_CTRL, `APU_OFF_ACT_TOFF, `APU_OFF_ACT_TON, `APU_OFF_STATUS: begin
                    // read-only: active set changes only through confirm
                    bresp_next = `APU_RESP_OKAY;
                end
                default: begin
                    bresp_next = `APU_RESP_SLVERR;
                end
            endcase
        end
        awready_next = !aw_hold_next && !bvalid_next;
        wready_next = !w_hold_next && !bvalid_next;
    end

    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            aw_hold_reg <= 1'b0;
            aw_addr_reg <= '0;
            w_hold_reg <= 1'b0;
            w_data_reg <= 32'h00000000;
            w_strb_reg <= 4'h0;
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= `APU_RESP_OKAY;
            edit_reg <= CFG_DEFAULT; // [R03] [R06]
            act_reg <= CFG_DEFAULT; // [R03] [R06] [R07] [R08]
        end else begin
            aw_hold_reg <= aw_hold_next;
            aw_addr_reg <= aw_addr_next;
            w_hold_reg <= w_hold_next;
            w_data_reg <= w_data_next;
            w_strb_reg <= w_strb_next;
            awready_reg <= awready_next;
            wready_reg <= wready_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            edit_reg <= edit_next;
            act_reg <= act_next;
        end
    end

    always_comb begin
        arready_next = arready_reg;
        rvalid_next = rvalid_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        if (rvalid_reg && S_AXI_RREADY_I) begin
            rvalid_next = 1'b0;
        end
        if (S_AXI_ARVALID_I && arready_reg) begin
            rvalid_next = 1'b1;
            rresp_next = `APU_RESP_OKAY;
            rdata_next = 32'h00000000;
            unique case (S_AXI_ARADDR_I)
                `APU_OFF_EDIT_CTRL: rdata_next = ctrl_word(edit_reg);
                `APU_OFF_EDIT_TOFF: rdata_next[`APU_TIME_W-1:0] = edit_reg.toff;
                `APU_OFF_EDIT_TON: rdata_next[`APU_TIME_W-1:0] = edit_reg.ton;
                `APU_OFF_COMMAND: rdata_next = 32'h00000000;
                `APU_OFF_ACT_CTRL: rdata_next = ctrl_word(act_reg);
                `APU_OFF_ACT_TOFF: rdata_next[`APU_TIME_W-1:0] = act_reg.toff;
                `APU_OFF_ACT_TON: rdata_next[`APU_TIME_W-1:0] = act_reg.ton;
                `APU_OFF_STATUS: begin
                    rdata_next[`APU_ST_ALARM_BIT] = sync2_reg;
                    rdata_next[`APU_ST_OUT_BIT] = out_reg;
                    rdata_next[`APU_ST_PHASE_LSB +: 2] = phase_reg;
                end
                default: rresp_next = `APU_RESP_SLVERR;
            endcase
        end
        arready_next = !rvalid_next;
    end

    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
            rresp_reg <= `APU_RESP_OKAY;
        end else begin
            arready_reg <= arready_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
        end
    end

    // second base is realigned at each phase start so phases are whole seconds
    apu_tick #(
        .CYC_PER_SEC(CYC_PER_SEC)
    ) u_tick (
        .clk_i(CLK_I),
        .resetn_i(RESETN_I),
        .restart_i(restart),
        .tick_o(tick)
    );

    always_comb begin
        phase_next = phase_reg;
        sec_next = sec_reg;
        if (!sync2_reg) begin
            phase_next = apu_pkg::APU_IDLE; // [R10]
            sec_next = '0; // [R10]
        end else begin
            unique case (phase_reg)
                apu_pkg::APU_IDLE: begin
                    phase_next = apu_pkg::APU_ON; // [R10]
                    sec_next = '0;
                end
                apu_pkg::APU_ON: begin
                    if (act_reg.cont) begin
                        sec_next = '0; // [R04]
                    end else if (tick) begin
                        if (sec_reg + `APU_TIME_MIN >= eff_time(act_reg.ton)) begin
                            phase_next = apu_pkg::APU_OFF; // [R05] [R08]
                            sec_next = '0;
                        end else begin
                            sec_next = sec_reg + `APU_TIME_MIN;
                        end
                    end
                end
                apu_pkg::APU_OFF: begin
                    if (act_reg.cont) begin
                        phase_next = apu_pkg::APU_ON; // [R04]
                        sec_next = '0;
                    end else if (tick) begin
                        if (sec_reg + `APU_TIME_MIN >= eff_time(act_reg.toff)) begin
                            phase_next = apu_pkg::APU_ON; // [R05] [R07]
                            sec_next = '0;
                        end else begin
                            sec_next = sec_reg + `APU_TIME_MIN;
                        end
                    end
                end
                default: begin
                    phase_next = apu_pkg::APU_IDLE;
                    sec_next = '0;
                end
            endcase
        end
        // active level is 1 for high-active, 0 for low-active
        out_next = (phase_next == apu_pkg::APU_ON) ^ act_reg.low_act; // [R01] [R02]
    end

    assign restart = (phase_next != phase_reg) || (phase_reg == apu_pkg::APU_IDLE);

    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            phase_reg <= apu_pkg::APU_IDLE;
            sec_reg <= '0;
            out_reg <= 1'b0; // [R01] [R03]
        end else begin
            phase_reg <= phase_next;
            sec_reg <= sec_next;
            out_reg <= out_next;
        end
    end

    assign ALARM_O = out_reg;
    assign S_AXI_AWREADY_O = awready_reg;
    assign S_AXI_WREADY_O = wready_reg;
    assign S_AXI_BVALID_O = bvalid_reg;
    assign S_AXI_BRESP_O = bresp_reg;
    assign S_AXI_ARREADY_O = arready_reg;
    assign S_AXI_RVALID_O = rvalid_reg;
    assign S_AXI_RDATA_O = rdata_reg;
    assign S_AXI_RRESP_O = rresp_reg;

endmodule

`default_nettype wire

// file: shared/apu_consts.svh
/*
 constants for the alarm output pulser: register offsets, field positions,
 reset values and timing figures.
 assumes: included by bare name from shared/, no code of its own.
*/
`ifndef APU_CONSTS_SVH
`define APU_CONSTS_SVH

`define APU_ADDR_W 8
`define APU_OFF_EDIT_CTRL 8'h00
`define APU_OFF_EDIT_TOFF 8'h04
`define APU_OFF_EDIT_TON 8'h08
`define APU_OFF_COMMAND 8'h0c
`define APU_OFF_ACT_CTRL 8'h10
`define APU_OFF_ACT_TOFF 8'h14
`define APU_OFF_ACT_TON 8'h18
`define APU_OFF_STATUS 8'h1c

`define APU_CTRL_LOW_BIT 0
`define APU_CTRL_CONT_BIT 1
`define APU_CMD_APPLY_BIT 0
`define APU_CMD_CANCEL_BIT 1
`define APU_CMD_DEFAULT_BIT 2
`define APU_ST_ALARM_BIT 0
`define APU_ST_OUT_BIT 1
`define APU_ST_PHASE_LSB 2

`define APU_TIME_W 16
`define APU_DEF_LOW_ACT 1'b0
`define APU_DEF_CONT 1'b0
`define APU_DEF_TOFF 16'h0005
`define APU_DEF_TON 16'h0005
`define APU_TIME_MIN 16'h0001

`define APU_RESP_OKAY 2'b00
`define APU_RESP_SLVERR 2'b10

`define APU_SECOND_NS 1000000000
`define APU_CLK_PERIOD_NS 10
`define APU_CYC_PER_SEC (`APU_SECOND_NS / `APU_CLK_PERIOD_NS)

`endif

// file: shared/apu_pkg.sv
/*
 types for the alarm output pulser: settings record and phase states.
 assumes: nothing beyond the consts header.
*/
`include "apu_consts.svh"

package apu_pkg;

    typedef struct packed {
        logic low_act;
        logic cont;
        logic [`APU_TIME_W-1:0] toff;
        logic [`APU_TIME_W-1:0] ton;
    } apu_cfg_t;

    typedef enum logic [1:0] {
        APU_IDLE = 2'b00,
        APU_ON = 2'b01,
        APU_OFF = 2'b10
    } apu_phase_t;

endpackage

// file: hw/apu_tick.sv
/*
 one-second tick generator for the alarm pulser phase timer.
 assumes: single clock, async active-low reset; restart_i realigns the second.
*/
`timescale 1ns/1ps
`default_nettype none
`include "apu_consts.svh"

module apu_tick #(
    parameter int unsigned CYC_PER_SEC = `APU_CYC_PER_SEC
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic restart_i,
    output logic tick_o
);

    logic [31:0] cnt_reg;
    logic [31:0] cnt_next;
    logic tick_reg;
    logic tick_next;

    always_comb begin
        cnt_next = cnt_reg + 32'h00000001;
        tick_next = 1'b0;
        if (restart_i) begin
            cnt_next = 32'h00000000;
        end else if (cnt_reg >= CYC_PER_SEC - 1) begin
            cnt_next = 32'h00000000;
            tick_next = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_reg <= 32'h00000000;
            tick_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            tick_reg <= tick_next;
        end
    end

    assign tick_o = tick_reg;

endmodule

`default_nettype wire

// file: verification/apu_pulser_props.sv
/*
 checker for the alarm pulser: axi handshakes and alarm pin timing.
 assumes: bound to apu_pulser, one clock, no mid-alarm apply.
*/
`timescale 1ns/1ps
`default_nettype none
`include "apu_consts.svh"
module apu_pulser_props #(
    parameter int unsigned CYC_PER_SEC = `APU_CYC_PER_SEC
) (
    input wire logic CLK_I,
    input wire logic RESETN_I,
    input wire logic ALARM_I,
    input wire logic ALARM_O,
    input wire logic S_AXI_AWVALID_I,
    input wire logic S_AXI_AWREADY_O,
    input wire logic S_AXI_WVALID_I,
    input wire logic S_AXI_WREADY_O,
    input wire logic [1:0] S_AXI_BRESP_O,
    input wire logic S_AXI_BVALID_O,
    input wire logic S_AXI_BREADY_I,
    input wire logic S_AXI_ARVALID_I,
    input wire logic S_AXI_ARREADY_O,
    input wire logic [31:0] S_AXI_RDATA_O,
    input wire logic S_AXI_RVALID_O,
    input wire logic S_AXI_RREADY_I
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RESETN_I);
    logic last_reg;
    int unsigned run_reg;
    int unsigned run_next;
    // cycles since the pin last moved; a counter, since repetition cannot reach a second
    always_comb begin
        run_next = (ALARM_O != last_reg) ? 0 : run_reg + 1;
    end
    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            last_reg <= 1'b0;
            run_reg <= 0;
        end else begin
            last_reg <= ALARM_O;
            run_reg <= run_next;
        end
    end
    a_idle_steady: assert property (
        (!ALARM_I && !S_AXI_BVALID_O) [*5] |-> $stable(ALARM_O)) else $error("pin moved while idle");
    a_start_on: assert property (
        (!ALARM_I [*4] ##1 ALARM_I) |-> ##[2:4] (ALARM_O != last_reg)) else $error("no on phase at start");
    a_phase_min: assert property (
        (ALARM_I [*6] ##0 (ALARM_O != last_reg)) |-> run_reg + 1 >= CYC_PER_SEC)
        else $error("pulse phase too short");
    a_aw_taken: assert property (
        S_AXI_AWVALID_I && S_AXI_AWREADY_O |=> !S_AXI_AWREADY_O) else $error("awready stayed high");
    a_ar_taken: assert property (
        S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O && !S_AXI_ARREADY_O) else $error("read answer late");
    a_b_after_both: assert property (
        S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O |-> ##[1:2] S_AXI_BVALID_O)
        else $error("write answer late");
    a_b_holds: assert property (
        S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O)) else $error("bresp dropped");
    a_r_holds: assert property (
        S_AXI_RVALID_O && !S_AXI_RREADY_I |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O)) else $error("rdata dropped");
    c_write: cover property (S_AXI_AWVALID_I && S_AXI_AWREADY_O);
    c_read: cover property (S_AXI_ARVALID_I && S_AXI_ARREADY_O);
    c_alarm: cover property ($rose(ALARM_I));
endmodule
bind apu_pulser apu_pulser_props #(.CYC_PER_SEC(CYC_PER_SEC)) u_props (.*);
`default_nettype wire

// file: verification/apu_siren.sv
/*
 siren input model: watches the alarm pin, reports the length of each
 finished level run and how many times the pin moved.
 assumes: purely a listener; it drives nothing back.
*/
`timescale 1ns/1ps
`default_nettype none
module apu_siren (
    input wire logic clk_i,
    input wire logic line_i,
    output int unsigned run_o,
    output int unsigned changes_o
);
    logic last_lvl;
    int unsigned cnt;
    initial begin
        run_o = 0;
        changes_o = 0;
        cnt = 0;
        last_lvl = 1'b0;
    end
    always @(posedge clk_i) begin
        if (line_i !== last_lvl) begin
            run_o <= cnt;
            changes_o <= changes_o + 1;
            cnt <= 1;
        end else begin
            cnt <= cnt + 1;
        end
        last_lvl <= line_i;
    end
endmodule
`default_nettype wire

// file: verification/apu_pulser_tb_top.sv
/*
 testbench for the alarm pulser: registers over axi4-lite, siren model on the pin.
 assumes: one second shortened to CPS cycles.
*/
`timescale 1ns/1ps
`default_nettype none
`include "apu_consts.svh"
module apu_pulser_tb_top;
    localparam int unsigned CPS = 20;
    logic clk, rstn, alarm, alarm_o;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [1:0] bresp, rresp, r;
    int unsigned run, chg;
    int error_cnt = 0;
    int checks_done = 0;
    apu_pulser #(.CYC_PER_SEC(CPS)) dut (.CLK_I(clk), .RESETN_I(rstn), .ALARM_I(alarm), .ALARM_O(alarm_o),
        .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
        .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready),
        .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
        .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready),
        .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready));
    apu_siren u_siren (.clk_i(clk), .line_i(alarm_o), .run_o(run), .changes_o(chg));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic conclude;
        $display("errors %0d checks %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic ok, input string m);
        checks_done++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("MISMATCH t=%0t %s", $time, m);
        end
    endtask
    task automatic hang(input int n);
        if (n >= 60) begin
            chk(1'b0, "bus timeout");
            conclude;
        end
    endtask
    // leading edge keeps the previous task's release apart from the new request
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] re = `APU_RESP_OKAY);
        int n;
        @(posedge clk);
        awaddr <= a; wdata <= d; wstrb <= 4'hf; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        for (n = 0; n < 60; n++) begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        hang(n);
        chk(bresp === re, "write answer");
        bready <= 1'b0;
    endtask
    // ready raised only once the answer shows, so the slave must hold it
    task automatic t_late_ready;
        int n;
        @(posedge clk);
        awaddr <= `APU_OFF_ACT_CTRL; wdata <= 32'h3; wstrb <= 4'hf; awvalid <= 1'b1; wvalid <= 1'b1;
        for (n = 0; n < 60; n++) begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready) break;
            if (bvalid) bready <= 1'b1;
        end
        hang(n);
        chk(bresp === `APU_RESP_OKAY, "late write answer");
        bready <= 1'b0;
        @(posedge clk);
        araddr <= `APU_OFF_ACT_CTRL; arvalid <= 1'b1;
        for (n = 0; n < 60; n++) begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && rready) break;
            if (rvalid) rready <= 1'b1;
        end
        hang(n);
        chk(rdata === 32'h0 && rresp === `APU_RESP_OKAY, "read-only ctrl written");
        rready <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] re, input string m);
        int n;
        @(posedge clk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        for (n = 0; n < 60; n++) begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        hang(n);
        chk(rdata === e && rresp === re, m);
        rready <= 1'b0;
    endtask
    task automatic next_run(output int unsigned n);
        int unsigned c0;
        int k;
        c0 = chg;
        for (k = 0; k < 3000 && chg == c0; k++) @(posedge clk);
        if (chg == c0) begin
            chk(1'b0, "pin never moved");
            conclude;
        end
        n = run;
    endtask
    // one on and one off phase measured, then the alarm ends as the next on phase starts
    task automatic t_pulse(input int unsigned ton, input int unsigned toff, input logic act);
        int unsigned n;
        alarm <= 1'b1;
        repeat (5) @(posedge clk);
        chk(alarm_o === act, "alarm did not open active");
        rdc(`APU_OFF_STATUS, act ? 32'h7 : 32'h5, `APU_RESP_OKAY, "status in on phase");
        next_run(n);
        chk(n + 2 >= ton * CPS && n <= ton * CPS + 2 && alarm_o === ~act, "on time");
        next_run(n);
        chk(n + 2 >= toff * CPS && n <= toff * CPS + 2 && alarm_o === act, "off time");
        alarm <= 1'b0;
        repeat (5) @(posedge clk);
        chk(alarm_o === ~act, "pin not released");
    endtask
    task automatic t_reset_vals;
        chk(alarm_o === 1'b0, "idle level");
        rdc(`APU_OFF_ACT_CTRL, 32'h0, `APU_RESP_OKAY, "reset ctrl");
        rdc(`APU_OFF_ACT_TOFF, 32'h5, `APU_RESP_OKAY, "reset off time");
        rdc(`APU_OFF_ACT_TON, 32'h5, `APU_RESP_OKAY, "reset on time");
        rdc(8'h20, 32'h0, `APU_RESP_SLVERR, "unmapped read");
        wr(8'h20, 32'h1, `APU_RESP_SLVERR);
    endtask
    task automatic t_cancel_apply;
        wr(`APU_OFF_EDIT_TON, 32'h2);
        wr(`APU_OFF_EDIT_TOFF, 32'h3);
        wr(`APU_OFF_COMMAND, 32'h2);
        rdc(`APU_OFF_ACT_TON, 32'h5, `APU_RESP_OKAY, "cancel changed active");
        rdc(`APU_OFF_EDIT_TON, 32'h5, `APU_RESP_OKAY, "cancel kept edit");
        wr(`APU_OFF_EDIT_TON, 32'h2);
        wr(`APU_OFF_EDIT_TOFF, 32'h3);
        rdc(`APU_OFF_ACT_TOFF, 32'h5, `APU_RESP_OKAY, "edit leaked early");
        wr(`APU_OFF_COMMAND, 32'h1);
        rdc(`APU_OFF_ACT_TOFF, 32'h3, `APU_RESP_OKAY, "apply off time");
        t_pulse(2, 3, 1'b1);
    endtask
    task automatic t_cont_low;
        int unsigned c0;
        wr(`APU_OFF_EDIT_CTRL, 32'h3);
        wr(`APU_OFF_COMMAND, 32'h1);
        repeat (3) @(posedge clk);
        chk(alarm_o === 1'b1, "low-active idle");
        alarm <= 1'b1;
        repeat (5) @(posedge clk);
        c0 = chg;
        chk(alarm_o === 1'b0, "low-active alarm");
        repeat (300) @(posedge clk);
        chk(chg == c0 && alarm_o === 1'b0, "continuous broke");
        alarm <= 1'b0;
        repeat (5) @(posedge clk);
        chk(alarm_o === 1'b1, "continuous release");
        wr(`APU_OFF_EDIT_CTRL, 32'h1);
        wr(`APU_OFF_COMMAND, 32'h1);
        t_pulse(2, 3, 1'b0);
    endtask
    task automatic t_defaults;
        wr(`APU_OFF_COMMAND, 32'h5);
        rdc(`APU_OFF_ACT_CTRL, 32'h0, `APU_RESP_OKAY, "default ctrl");
        rdc(`APU_OFF_ACT_TON, 32'h5, `APU_RESP_OKAY, "default on time");
        chk(alarm_o === 1'b0, "default polarity");
        t_pulse(5, 5, 1'b1);
    endtask
    initial begin
        rstn = 1'b0; alarm = 1'b0; awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; wstrb = 4'h0;
        awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        t_reset_vals;
        t_late_ready;
        t_cancel_apply;
        t_cont_low;
        t_defaults;
        conclude;
    end
endmodule
`default_nettype wire
